// ===== dv/pix_source.sv
`timescale 1ns/10ps
`default_nettype none
module pix_source
   import pix_pkg::*;
(
   input wire logic pclk,
   input wire logic in_ready,
   output logic in_valid,
   output logic [PIX_W-1:0] in_data
);
   initial
   begin
      in_valid = 1'b0;
      in_data = '0;
   end
   // one beat held until taken; afterwards the data lines show junk
   task automatic send(input logic [PIX_W-1:0] px);
      @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= px;
      @(posedge pclk);
      while (in_ready !== 1'b1)
         @(posedge pclk);
      in_valid <= 1'b0;
      in_data <= ~px;
   endtask
endmodule
`default_nettype wire

// ===== dv/pixel_proc_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pixel_proc_tb_top
   import pix_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [PIX_W-1:0] in_data, out_data;
   logic [PIX_W-1:0] got_q[$];
   int errors, compares, cycles, i;
   logic [31:0] r;
   logic e;

   pixel_proc pixel_proc_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
   pix_source pix_source_i (.pclk(pclk), .in_ready(in_ready),
      .in_valid(in_valid), .in_data(in_data));

   initial
   begin
      pclk = 1'b0;
      forever
         #4 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      if (out_valid === 1'b1 && out_ready === 1'b1)
         got_q.push_back(out_data);
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         results();
      end
   end

   task automatic results();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rv, output logic ev);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rv;
      logic ev;
      apb(1'b1, a, d, rv, ev);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] rv;
      logic ev;
      apb(1'b0, a, 32'h0000_0000, rv, ev);
      chk($sformatf("reg %h", a), rv, x);
   endtask

   task automatic pop_chk(input logic [PIX_W-1:0] x);
      if (got_q.size() == 0)
         chk("pixel", 32'hxxxx_xxxx, {8'h00, x});
      else
         chk("pixel", {8'h00, got_q.pop_front()}, {8'h00, x});
   endtask

   task automatic px(input logic [PIX_W-1:0] pi, x);
      pix_source_i.send(pi);
      repeat (3) @(posedge pclk);
      pop_chk(x);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      out_ready = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(CTRL_OFS, 32'h0000_0000);
      rd(CLIP_VAL_OFS, 32'h0000_00ff);
      rd(RATIO_VAL_OFS, 32'h0000_0100);
      rd(TBL_IDX_OFS, 32'h0000_0000);
      apb(1'b0, 8'h30, 32'h0000_0000, r, e);
      chk("unmapped err", {31'h0, e}, 32'h0000_0001);
      px(24'h302010, 24'h302010);
      // red table entry loaded and enabled
      wr(TBL_SEL_OFS, 32'h0000_0001);
      wr(TBL_IDX_OFS, 32'h0000_0010);
      wr(TBL_VAL_OFS, 32'h0000_0055);
      rd(TBL_VAL_OFS, 32'h0000_0055);
      wr(TBL_EN_OFS, 32'h0000_0001);
      px(24'h302010, 24'h302055);
      wr(TBL_SEL_OFS, 32'h0000_0002);
      rd(TBL_VAL_OFS, 32'h0000_0010);
      wr(TBL_SEL_OFS, 32'h0000_0001);
      wr(TBL_EN_OFS, 32'h0000_0000);
      px(24'h302010, 24'h302010);
      // green ceiling alone, then a red ceiling added
      wr(CLIP_SEL_OFS, {28'h0, SEL_GREEN});
      wr(CLIP_VAL_OFS, 32'h0000_0018);
      px(24'h302010, 24'h301810);
      wr(CLIP_SEL_OFS, {28'h0, SEL_RED});
      rd(CLIP_VAL_OFS, 32'h0000_00ff);
      wr(CLIP_VAL_OFS, 32'h0000_000c);
      px(24'h302010, 24'h30180c);
      wr(CLIP_VAL_OFS, 32'h0000_00ff);
      wr(CLIP_SEL_OFS, {28'h0, SEL_GREEN});
      wr(CLIP_VAL_OFS, 32'h0000_00ff);
      // ratios: blue doubled and saturated, tap1 halved, zero refused
      wr(RATIO_SEL_OFS, {28'h0, SEL_BLUE});
      wr(RATIO_VAL_OFS, 32'h0000_0200);
      px(24'h902010, 24'hff2010);
      wr(RATIO_VAL_OFS, 32'h0000_0000);
      rd(RATIO_VAL_OFS, 32'h0000_0200);
      wr(RATIO_SEL_OFS, {28'h0, SEL_TAP1});
      wr(RATIO_VAL_OFS, 32'h0000_0080);
      px(24'h102040, 24'h202020);
      wr(RATIO_SEL_OFS, {28'h0, SEL_ALL});
      wr(RATIO_VAL_OFS, 32'h0000_0100);
      wr(RATIO_SEL_OFS, {28'h0, SEL_V});
      rd(RATIO_VAL_OFS, 32'h0000_0100);
      px(24'h102040, 24'h102040);
      // bulk access on the blue table
      wr(TBL_SEL_OFS, 32'h0000_0003);
      wr(TBL_BULK_OFS, 32'h1312_1110);
      wr(TBL_SEL_OFS, 32'h0000_0003);
      rd(TBL_BULK_OFS, 32'h1312_1110);
      rd(TBL_BULK_OFS, 32'h0706_0504);
      wr(TBL_IDX_OFS, 32'h0000_0002);
      rd(TBL_VAL_OFS, 32'h0000_0012);
      // gamma locks the luminance table
      wr(TBL_SEL_OFS, 32'h0000_0000);
      wr(TBL_IDX_OFS, 32'h0000_0005);
      wr(CTRL_OFS, 32'h0000_0004);
      wr(TBL_VAL_OFS, 32'h0000_0099);
      rd(TBL_VAL_OFS, 32'h0000_0005);
      rd(STATUS_OFS, 32'h0000_0002);
      wr(GAMMA_OFS, 32'h0000_0000);
      rd(GAMMA_OFS, 32'h0000_0100);
      wr(CTRL_OFS, 32'h0000_0000);
      // receiver stall: two words held, nothing lost
      out_ready <= 1'b0;
      pix_source_i.send(24'h010203);
      pix_source_i.send(24'h040506);
      repeat (2) @(posedge pclk);
      chk("in_ready full", {31'h0, in_ready}, 32'h0000_0000);
      out_ready <= 1'b1;
      repeat (4) @(posedge pclk);
      pop_chk(24'h010203);
      pop_chk(24'h040506);
      // single-shot balance on grey converges and turns itself off
      wr(CTRL_OFS, 32'h0000_0001);
      for (i = 0; i < 1100; i++)
         pix_source_i.send(24'h404040);
      repeat (4) @(posedge pclk);
      got_q.delete();
      rd(CTRL_OFS, 32'h0000_0000);
      rd(STATUS_OFS, 32'h0000_0000);
      // continuous balance pulls a strong blue down and stays on
      wr(CTRL_OFS, 32'h0000_0002);
      for (i = 0; i < 2100; i++)
         pix_source_i.send(24'h804040);
      repeat (4) @(posedge pclk);
      got_q.delete();
      rd(CTRL_OFS, 32'h0000_0002);
      wr(RATIO_SEL_OFS, {28'h0, SEL_BLUE});
      apb(1'b0, RATIO_VAL_OFS, 32'h0000_0000, r, e);
      chk("blue ratio lowered", {31'h0, r < 32'h0000_0100}, 32'h1);
      wr(CTRL_OFS, 32'h0000_0000);
      results();
   end
endmodule
`default_nettype wire

// ===== logic/pix_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module pix_buffer
   import pix_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   pix_stream_if.snk up,
   pix_stream_if.src down
);
   logic [1:0] count_reg;
   logic [1:0] count_next;
   logic valid_reg;
   logic ready_reg;
   pixel_t mem_reg [BUF_DEPTH];

   wire push = up.valid & ready_reg;
   wire pop = valid_reg & down.ready;
   wire [1:0] wr_slot = count_reg - {1'b0, pop};

   assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
   assign up.ready = ready_reg;
   assign down.valid = valid_reg;
   assign down.data = mem_reg[0];

   // head slot is the output; slots shift down on a pop
   for (genvar i = 0; i < BUF_DEPTH; i++)
   begin : g_slot
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            mem_reg[i] <= '0;
         else if (push && wr_slot == 2'(i))
            mem_reg[i] <= up.data;
         else if (pop && i < BUF_DEPTH - 1)
            mem_reg[i] <= mem_reg[(i + 1) % BUF_DEPTH];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_reg <= '0;
         valid_reg <= 1'b0;
         ready_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         valid_reg <= count_next != 2'h0;
         ready_reg <= count_next != 2'(BUF_DEPTH);
      end
   end

   buf_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_reg == 2'(BUF_DEPTH) |-> !up.ready && down.valid)
      else $error("buffer full but still ready");
endmodule
`default_nettype wire

// ===== logic/pix_pkg.sv
package pix_pkg;
   localparam int COMP_W = 8;
   localparam int N_COMP = 3;
   localparam int RATIO_W = 16;
   localparam int TBL_N = 4;
   localparam int TBL_DEPTH = 256;
   localparam int IDX_W = 8;
   localparam int LANES = 4;
   localparam int BULK_W = 6;
   localparam int BUF_DEPTH = 2;
   localparam int WIN_W = 10;
   localparam int SUM_W = COMP_W + WIN_W;
   localparam int PIX_W = COMP_W * N_COMP;

   typedef logic [COMP_W-1:0] comp_t;
   typedef comp_t [N_COMP-1:0] pixel_t;
   typedef logic [RATIO_W-1:0] ratio_t;
   typedef enum logic [1:0] {WB_OFF, WB_ONCE, WB_CONT} wb_mode_t;
   typedef enum logic [1:0] {TBL_LUM, TBL_RED, TBL_GREEN, TBL_BLUE}
      table_sel_t;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CLIP_SEL_OFS = 8'h04;
   localparam logic [7:0] CLIP_VAL_OFS = 8'h08;
   localparam logic [7:0] RATIO_SEL_OFS = 8'h0c;
   localparam logic [7:0] RATIO_VAL_OFS = 8'h10;
   localparam logic [7:0] GAMMA_OFS = 8'h14;
   localparam logic [7:0] TBL_SEL_OFS = 8'h18;
   localparam logic [7:0] TBL_EN_OFS = 8'h1c;
   localparam logic [7:0] TBL_IDX_OFS = 8'h20;
   localparam logic [7:0] TBL_VAL_OFS = 8'h24;
   localparam logic [7:0] TBL_BULK_OFS = 8'h28;
   localparam logic [7:0] STATUS_OFS = 8'h2c;

   // field positions
   localparam int CTRL_GAMMA_BIT = 2;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_GAMMA_BIT = 1;

   // channel selector codes
   localparam logic [3:0] SEL_ALL = 4'h0;
   localparam logic [3:0] SEL_RED = 4'h1;
   localparam logic [3:0] SEL_GREEN = 4'h2;
   localparam logic [3:0] SEL_BLUE = 4'h3;
   localparam logic [3:0] SEL_Y = 4'h4;
   localparam logic [3:0] SEL_U = 4'h5;
   localparam logic [3:0] SEL_V = 4'h6;
   localparam logic [3:0] SEL_TAP1 = 4'h7;
   localparam logic [3:0] SEL_TAP2 = 4'h8;
   localparam logic [3:0] SEL_TAP3 = 4'h9;

   // reset values and auto balance figures
   localparam comp_t CLIP_RST = 8'hff;
   localparam ratio_t RATIO_ONE = 16'h0100;
   localparam ratio_t RATIO_STEP = 16'h0001;
   localparam ratio_t RATIO_MAX = 16'hffff;
   localparam int RATIO_FRAC = 8;
   localparam logic [SUM_W:0] WB_TOL = 19'h00400;
   localparam logic [WIN_W-1:0] WIN_LAST = 10'h3ff;
endpackage

// ===== logic/pix_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pix_stream_if
   import pix_pkg::*;
   ();
   logic valid;
   logic ready;
   pixel_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/pix_tables.sv
`timescale 1ns/10ps
`default_nettype none
module pix_tables
   import pix_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire pixel_t pix_in,
   input wire logic [TBL_N-1:0] tbl_en,
   input wire logic gamma_on,
   output pixel_t pix_out,
   input wire table_sel_t host_tbl,
   input wire logic [IDX_W-1:0] host_base,
   input wire logic [LANES-1:0] host_we,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata
);
   comp_t mem_reg [TBL_N][TBL_DEPTH];
   pixel_t col;

   // storage resets to the identity curve
   for (genvar t = 0; t < TBL_N; t++)
   begin : g_tbl
      for (genvar i = 0; i < TBL_DEPTH; i++)
      begin : g_ent
         logic [LANES-1:0] hit;
         for (genvar l = 0; l < LANES; l++)
         begin : g_lane
            assign hit[l] = host_we[l] && host_tbl == table_sel_t'(t)
               && IDX_W'(host_base + IDX_W'(l)) == IDX_W'(i);
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mem_reg[t][i] <= COMP_W'(i);
            else if (hit[0])
               mem_reg[t][i] <= host_wdata[COMP_W-1:0];
            else if (hit[1])
               mem_reg[t][i] <= host_wdata[2*COMP_W-1:COMP_W];
            else if (hit[2])
               mem_reg[t][i] <= host_wdata[3*COMP_W-1:2*COMP_W];
            else if (hit[3])
               mem_reg[t][i] <= host_wdata[4*COMP_W-1:3*COMP_W];
         end
      end
   end

   for (genvar l = 0; l < LANES; l++)
   begin : g_rd
      assign host_rdata[l*COMP_W +: COMP_W] =
         mem_reg[host_tbl][IDX_W'(host_base + IDX_W'(l))];
   end

   // colour tables first, then luminance or gamma curve on every component
   wire use_lum = tbl_en[TBL_LUM] | gamma_on;
   for (genvar c = 0; c < N_COMP; c++)
   begin : g_path
      assign col[c] = tbl_en[c + 1] ? mem_reg[c + 1][pix_in[c]]
         : pix_in[c];
      assign pix_out[c] = use_lum ? mem_reg[TBL_LUM][col[c]]
         : col[c];
   end

   table_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
      tbl_en == '0 && !gamma_on |-> pix_out == pix_in)
      else $error("disabled tables altered a pixel");
endmodule
`default_nettype wire

// ===== logic/pixel_proc.sv
// How it works
// - each channel is saturated at its clip ceiling; the tables applied after the clip can map it above
// - a clip write lands only on the channel the clip selector names
// - ratio selector picks all, red, green, blue, y, u, v or a tap
// - component times its ratio; a zero ratio write is refused
// - with auto balance off only software writes change the ratios
// - single-shot auto balance adjusts until converged, then turns off
// - continuous auto balance keeps adjusting while it stays selected
// - gamma exponent is kept positive; output follows the loaded curve
// - gamma uses the luminance table, locking its writes while active
// - table selector picks luminance, red, green or blue table
// - enable flag puts the selected table in or out of the path
// - entry index picks which coefficient the value register reaches
// - value read returns the indexed entry; a write stores it
// - bulk register streams the whole table, four entries a word
// - selector kept because four tables exist to choose between
`timescale 1ns/10ps
`default_nettype none
module pixel_proc
   import pix_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire logic [PIX_W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [PIX_W-1:0] out_data,
   input wire logic out_ready
);
   function automatic logic [N_COMP-1:0] chan_mask(input logic [3:0] sel);
      if (sel == SEL_ALL)
         chan_mask = 3'h7;
      else if (sel == SEL_RED || sel == SEL_Y || sel == SEL_TAP1)
         chan_mask = 3'h1;
      else if (sel == SEL_GREEN || sel == SEL_U || sel == SEL_TAP2)
         chan_mask = 3'h2;
      else if (sel == SEL_BLUE || sel == SEL_V || sel == SEL_TAP3)
         chan_mask = 3'h4;
      else
         chan_mask = 3'h0;
   endfunction

   pix_stream_if in_s ();
   pix_stream_if out_s ();

   wb_mode_t mode_reg;
   logic gamma_en_reg;
   ratio_t gamma_reg;
   logic [3:0] clip_sel_reg;
   comp_t clip_all_reg;
   comp_t clip_reg [N_COMP];
   logic [3:0] ratio_sel_reg;
   ratio_t ratio_reg [N_COMP];
   table_sel_t tbl_sel_reg;
   logic [TBL_N-1:0] tbl_en_reg;
   logic [IDX_W-1:0] tbl_idx_reg;
   logic [BULK_W-1:0] bulk_ptr_reg;
   logic [WIN_W-1:0] win_cnt_reg;
   logic [SUM_W-1:0] sum_reg [N_COMP];
   logic lock_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata;
   logic [31:0] tbl_rdata;
   logic mapped;

   // apb decode
   wire setup = psel & ~penable;
   wire access = psel & penable & pready_reg;
   wire wr = access & pwrite;
   wire rd = access & ~pwrite;
   wire wr_ctrl = wr && paddr == CTRL_OFS;
   wire wr_csel = wr && paddr == CLIP_SEL_OFS;
   wire wr_clip = wr && paddr == CLIP_VAL_OFS;
   wire wr_rsel = wr && paddr == RATIO_SEL_OFS;
   wire wr_ratio = wr && paddr == RATIO_VAL_OFS
      && pwdata[RATIO_W-1:0] != '0;
   wire wr_gamma = wr && paddr == GAMMA_OFS
      && pwdata[RATIO_W-1:0] != '0;
   wire wr_tsel = wr && paddr == TBL_SEL_OFS;
   wire wr_ten = wr && paddr == TBL_EN_OFS;
   wire wr_tidx = wr && paddr == TBL_IDX_OFS;
   wire tbl_locked = gamma_en_reg && tbl_sel_reg == TBL_LUM;
   wire wr_tval = wr && paddr == TBL_VAL_OFS && !tbl_locked;
   wire bulk_hit = access && paddr == TBL_BULK_OFS;
   wire wr_bulk = bulk_hit && pwrite && !tbl_locked;
   wire [N_COMP-1:0] clip_mask = chan_mask(clip_sel_reg);
   wire [N_COMP-1:0] ratio_mask = chan_mask(ratio_sel_reg);
   wire [IDX_W-1:0] host_base = (paddr == TBL_BULK_OFS)
      ? {bulk_ptr_reg, 2'b00} : tbl_idx_reg;
   wire [LANES-1:0] host_we = wr_bulk ? 4'hf : {3'h0, wr_tval};

   always_comb
   begin
      mapped = 1'b1;
      if (paddr == CTRL_OFS)
         rdata = {29'h0, gamma_en_reg, mode_reg};
      else if (paddr == CLIP_SEL_OFS)
         rdata = {28'h0, clip_sel_reg};
      else if (paddr == CLIP_VAL_OFS)
         rdata = {24'h0, clip_sel_reg == SEL_ALL ? clip_all_reg
            : clip_mask[0] ? clip_reg[0] : clip_mask[1] ? clip_reg[1]
            : clip_mask[2] ? clip_reg[2] : 8'h00};
      else if (paddr == RATIO_SEL_OFS)
         rdata = {28'h0, ratio_sel_reg};
      else if (paddr == RATIO_VAL_OFS)
         rdata = {16'h0, ratio_mask[0] ? ratio_reg[0]
            : ratio_mask[1] ? ratio_reg[1]
            : ratio_mask[2] ? ratio_reg[2] : 16'h0000};
      else if (paddr == GAMMA_OFS)
         rdata = {16'h0, gamma_reg};
      else if (paddr == TBL_SEL_OFS)
         rdata = {30'h0, tbl_sel_reg};
      else if (paddr == TBL_EN_OFS)
         rdata = {31'h0, tbl_en_reg[tbl_sel_reg]};
      else if (paddr == TBL_IDX_OFS)
         rdata = {24'h0, tbl_idx_reg};
      else if (paddr == TBL_VAL_OFS)
         rdata = {24'h0, tbl_rdata[COMP_W-1:0]};
      else if (paddr == TBL_BULK_OFS)
         rdata = tbl_rdata;
      else if (paddr == STATUS_OFS)
         rdata = {30'h0, gamma_en_reg, lock_reg};
      else
      begin
         rdata = 32'h0;
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end
      else
      begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg <= setup ? rdata : prdata_reg;
      end
   end

   // pixel path: balance, clip, then tables
   pixel_t pix_in;
   pixel_t bal;
   pixel_t clipped;
   comp_t ceil_eff [N_COMP];
   wire beat = in_valid & in_s.ready;
   wire auto_on = mode_reg != WB_OFF;
   wire win_end = beat && auto_on && win_cnt_reg == WIN_LAST;
   logic [N_COMP-1:0] step;
   logic [N_COMP-1:0] step_up;

   assign pix_in = in_data;
   for (genvar c = 0; c < N_COMP; c++)
   begin : g_chan
      wire [COMP_W+RATIO_W-1:0] prod = pix_in[c] * ratio_reg[c];
      wire [RATIO_W-1:0] scaled = prod[COMP_W+RATIO_W-1:RATIO_FRAC];
      wire signed [SUM_W:0] diff = $signed({1'b0, sum_reg[c]})
         - $signed({1'b0, sum_reg[1]});
      wire [SUM_W:0] mag = diff[SUM_W] ? (SUM_W+1)'(0) - diff : diff;
      assign bal[c] = scaled > RATIO_W'(CLIP_RST) ? CLIP_RST
         : scaled[COMP_W-1:0];
      assign ceil_eff[c] = clip_reg[c] < clip_all_reg ? clip_reg[c]
         : clip_all_reg;
      assign clipped[c] = bal[c] > ceil_eff[c] ? ceil_eff[c]
         : bal[c];
      assign step[c] = win_end && c != 1 && mag > WB_TOL;
      assign step_up[c] = diff[SUM_W];

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            clip_reg[c] <= CLIP_RST;
         else if (wr_clip && clip_sel_reg != SEL_ALL && clip_mask[c])
            clip_reg[c] <= pwdata[COMP_W-1:0];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            ratio_reg[c] <= RATIO_ONE;
         else if (wr_ratio && ratio_mask[c])
            ratio_reg[c] <= pwdata[RATIO_W-1:0];
         else if (step[c] && step_up[c] && ratio_reg[c] != RATIO_MAX)
            ratio_reg[c] <= ratio_reg[c] + RATIO_STEP;
         else if (step[c] && !step_up[c] && ratio_reg[c] > RATIO_STEP)
            ratio_reg[c] <= ratio_reg[c] - RATIO_STEP;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            sum_reg[c] <= '0;
         else if (!auto_on || win_end)
            sum_reg[c] <= '0;
         else if (beat)
            sum_reg[c] <= sum_reg[c] + SUM_W'(bal[c]);
      end
   end

   wire converged = win_end && step == '0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg <= WB_OFF;
         gamma_en_reg <= 1'b0;
         gamma_reg <= RATIO_ONE;
         clip_sel_reg <= SEL_ALL;
         clip_all_reg <= CLIP_RST;
         ratio_sel_reg <= SEL_ALL;
         tbl_sel_reg <= TBL_LUM;
         tbl_en_reg <= '0;
         tbl_idx_reg <= '0;
         bulk_ptr_reg <= '0;
         win_cnt_reg <= '0;
         lock_reg <= 1'b0;
      end
      else
      begin
         if (wr_ctrl && pwdata[1:0] != 2'h3)
            mode_reg <= wb_mode_t'(pwdata[1:0]);
         else if (converged && mode_reg == WB_ONCE)
            mode_reg <= WB_OFF;
         if (wr_ctrl)
            gamma_en_reg <= pwdata[CTRL_GAMMA_BIT];
         if (wr_gamma)
            gamma_reg <= pwdata[RATIO_W-1:0];
         if (wr_csel)
            clip_sel_reg <= pwdata[3:0];
         if (wr_clip && clip_sel_reg == SEL_ALL)
            clip_all_reg <= pwdata[COMP_W-1:0];
         if (wr_rsel)
            ratio_sel_reg <= pwdata[3:0];
         if (wr_tsel)
            tbl_sel_reg <= table_sel_t'(pwdata[1:0]);
         if (wr_ten)
            tbl_en_reg[tbl_sel_reg] <= pwdata[0];
         if (wr_tidx)
            tbl_idx_reg <= pwdata[IDX_W-1:0];
         if (wr_tsel)
            bulk_ptr_reg <= '0;
         else if (bulk_hit && !(pwrite && tbl_locked))
            bulk_ptr_reg <= bulk_ptr_reg + 6'h01;
         if (!auto_on)
            win_cnt_reg <= '0;
         else if (beat)
            win_cnt_reg <= win_cnt_reg + 10'h001;
         if (converged)
            lock_reg <= 1'b1;
         else if (win_end || !auto_on)
            lock_reg <= 1'b0;
      end
   end

   // four tables, so the selector stays in the map
   pix_tables u_tables (
      .pclk(pclk),
      .presetn(presetn),
      .pix_in(clipped),
      .tbl_en(tbl_en_reg),
      .gamma_on(gamma_en_reg),
      .pix_out(in_s.data),
      .host_tbl(tbl_sel_reg),
      .host_base(host_base),
      .host_we(host_we),
      .host_wdata(pwdata),
      .host_rdata(tbl_rdata)
   );

   assign in_s.valid = in_valid;
   assign out_s.ready = out_ready;

   pix_buffer u_buffer (
      .pclk(pclk),
      .presetn(presetn),
      .up(in_s.snk),
      .down(out_s.src)
   );

   assign in_ready = in_s.ready;
   assign out_valid = out_s.valid;
   assign out_data = out_s.data;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   clip_bound_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      clipped[0] <= ceil_eff[0] && clipped[1] <= ceil_eff[1]
      && clipped[2] <= ceil_eff[2])
      else $error("channel above its clip ceiling");
   clip_only_sel_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_clip && clip_sel_reg == SEL_RED |=> $stable(clip_reg[1])
      && $stable(clip_reg[2]) && clip_reg[0] == $past(pwdata[7:0]))
      else $error("clip write reached the wrong channel");
   ratio_zero_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr && paddr == RATIO_VAL_OFS && pwdata[15:0] == 16'h0000
      |=> $stable(ratio_reg[0]) && $stable(ratio_reg[2]))
      else $error("zero ratio accepted");
   wb_off_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      mode_reg == WB_OFF && !wr_ratio |=> $stable(ratio_reg[0])
      && $stable(ratio_reg[2]))
      else $error("ratio changed with auto balance off");
   once_return_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      mode_reg == WB_ONCE && converged && !wr_ctrl |=> mode_reg == WB_OFF)
      else $error("single-shot balance did not return to off");
   cont_stays_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      mode_reg == WB_CONT && !wr_ctrl |=> mode_reg == WB_CONT)
      else $error("continuous balance stopped by itself");
   gamma_pos_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      gamma_reg != 16'h0000)
      else $error("gamma exponent not positive");
   table_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_tval ##1 paddr == TBL_VAL_OFS && !wr_tidx
      |-> tbl_rdata[7:0] == $past(pwdata[7:0]))
      else $error("table entry not stored");
endmodule
`default_nettype wire
